// ---- serial_port_pkg.sv ----
/*
  Shared constants and carrier types for the asynchronous serial port.
  Assumes a single 25 MHz system clock and a synchronous active-low reset.
*/
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_DATA    = 4'h1;
  localparam logic [3:0] ADDR_RELOAD  = 4'h2;
  localparam logic [3:0] ADDR_TIMER   = 4'h3;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_MASK    = 4'h5;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int CTL_MODE   = 7;
  localparam int CTL_UNUSED = 6;
  localparam int CTL_MCE    = 5;
  localparam int CTL_REN    = 4;
  localparam int CTL_TB8    = 3;
  localparam int CTL_RB8    = 2;
  localparam int CTL_TI     = 1;
  localparam int CTL_RI     = 0;

  // Timer config: bit 2 = run, bits 1:0 = clock source
  localparam int TMR_RUN = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  localparam logic [2:0] TIMER_RESET   = 3'h0;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Prescaler terminal counts (divide by N means count N-1)
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT8_LAST  = 3'h7;

  // Frame lengths in bits after the start bit: data + (ninth) + stop
  localparam logic [3:0] BITS_MODE8 = 4'h9;
  localparam logic [3:0] BITS_MODE9 = 4'ha;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_DIV4  = 2'b00,
    SRC_DIV12 = 2'b01,
    SRC_DIV48 = 2'b10,
    SRC_EXT8  = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } rx_word_t;

endpackage

// ---- baud_counter.sv ----
/*
  One 8-bit auto-reload counter with a divide-by-two overflow stage.
  Assumes tick is a one-cycle enable from the timer clock prescaler.
*/
`timescale 1ns/1ns
module baud_counter (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       tick,
  input  wire logic       forceReload,
  input  wire logic [7:0] reloadByte,
  output logic [7:0]      count,
  output logic            bitTick
);

  logic [7:0] next_count;
  logic       half;
  logic       next_half;
  logic       next_bitTick;

  // ----------------------------------------------------------------
  // Count, reload on overflow, halve the overflow rate
  // ----------------------------------------------------------------
  always_comb begin
    next_count   = count;
    next_half    = half;
    next_bitTick = 1'b0;
    if (forceReload) begin
      next_count = reloadByte;
      next_half  = 1'b1; // First overflow is half a bit, so samples land mid-bit
    end else if (tick) begin
      if (count == 8'hff) begin
        next_count   = reloadByte;
        next_half    = ~half;
        next_bitTick = half;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count   <= serial_port_pkg::RELOAD_RESET;
      half    <= 1'b0;
      bitTick <= 1'b0;
    end else begin
      count   <= next_count;
      half    <= next_half;
      bitTick <= next_bitTick;
    end
  end

endmodule

// ---- async_serial_port.sv ----
/*
  Asynchronous full-duplex serial port with buffered receiver and baud timer.
  Assumes one 25 MHz clock, a plain register port and an external clock pin.
*/
// Function
// - Async full duplex port, 10-bit and 11-bit frame modes.
// - Receiver buffers a finished byte while the next one arrives.
// - One data address: read gives receive buffer, write loads transmit.
// - Interrupt requested when transmit-done or receive-done sets, if enabled.
// - Done flags stay set until software clears them.
// - Bit clock comes from an 8-bit auto-reload timer.
// - Transmit uses timer low count; receive uses a hidden duplicate.
// - Both counters' overflows are halved to give bit rates.
// - Duplicate counts when the timer runs, with the same reload byte.
// - Start condition on receive pin forces the duplicate to reload.
// - Bit rate is timer clock over (256 minus reload), halved.
// - Timer clock: system clock /4, /12, /48, or external clock /8.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 9-bit frame: start, eight data, programmable ninth bit, stop.
// - Receive loads only if flag clear and, with check on, bit is one.
// - Transmit starts on data write; done flag sets at stop bit start.
`timescale 1ns/1ns
module async_serial_port (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdata,
  input  wire logic       rxPin,
  input  wire logic       extClkPin,
  output logic            txPin,
  output logic            irq
);

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_t;

  serial_port_pkg::reg_req_t req;
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Width-matched register file state
  logic [7:0] control, next_control;
  logic [7:0] rxBuf, next_rxBuf;
  logic [7:0] reload, next_reload;
  logic [2:0] timerCfg, next_timerCfg;
  logic [1:0] irqMask, next_irqMask;
  logic [7:0] next_regRdata;
  logic       next_irq;

  // Pin synchronisers: first stage feeds only the second
  logic [1:0] rxSync, extSync;
  logic       extPrev;

  // Prescaler and baud timing
  logic [5:0] preCnt, next_preCnt;
  logic [2:0] extCnt, next_extCnt;
  logic       timerTick, next_timerTick;
  logic [7:0] txCount, rxCount;
  logic       txBitTick, rxBitTick;
  logic       startSeen;

  // Transmitter
  tx_state_t  txState, next_txState;
  logic [8:0] txShift, next_txShift;
  logic [3:0] txLeft, next_txLeft;
  logic       next_txPin;
  logic       txDoneSet;

  // Receiver
  rx_state_t  rxState, next_rxState;
  logic [8:0] rxShift, next_rxShift;
  logic [3:0] rxLeft, next_rxLeft;
  logic       rxPhase, next_rxPhase;
  logic       rxDoneSet;
  serial_port_pkg::rx_word_t rxWord;

  // Frame length in bits after start, chosen by the mode bit
  function automatic logic [3:0] frameBits(input logic mode9);
    frameBits = mode9 ? serial_port_pkg::BITS_MODE9 : serial_port_pkg::BITS_MODE8;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxSync  <= 2'b11;
      extSync <= 2'b00;
      extPrev <= 1'b0;
    end else begin
      rxSync  <= {rxSync[0], rxPin};
      extSync <= {extSync[0], extClkPin};
      extPrev <= extSync[1];
    end
  end

  // ----------------------------------------------------------------
  // Timer clock prescaler
  // ----------------------------------------------------------------
  // One-cycle enable; the external clock is edge-counted, so it must be
  // well below half the system clock
  always_comb begin
    logic [5:0] last;
    last           = serial_port_pkg::DIV4_LAST;
    next_preCnt    = preCnt + 6'h01;
    next_extCnt    = extCnt;
    next_timerTick = 1'b0;
    case (serial_port_pkg::clk_src_t'(timerCfg[1:0]))
      serial_port_pkg::SRC_DIV4:  last = serial_port_pkg::DIV4_LAST;
      serial_port_pkg::SRC_DIV12: last = serial_port_pkg::DIV12_LAST;
      serial_port_pkg::SRC_DIV48: last = serial_port_pkg::DIV48_LAST;
      default:                    last = serial_port_pkg::DIV48_LAST;
    endcase
    if (preCnt >= last) begin
      next_preCnt = 6'h00;
      if (timerCfg[1:0] != serial_port_pkg::SRC_EXT8) begin
        next_timerTick = timerCfg[serial_port_pkg::TMR_RUN];
      end
    end
    if (extSync[1] && !extPrev) begin
      next_extCnt = extCnt + 3'h1;
      if (extCnt == serial_port_pkg::EXT8_LAST &&
          timerCfg[1:0] == serial_port_pkg::SRC_EXT8) begin
        next_timerTick = timerCfg[serial_port_pkg::TMR_RUN];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      preCnt    <= 6'h00;
      extCnt    <= 3'h0;
      timerTick <= 1'b0;
    end else begin
      preCnt    <= next_preCnt;
      extCnt    <= next_extCnt;
      timerTick <= next_timerTick;
    end
  end

  // ----------------------------------------------------------------
  // Baud counters: visible transmit counter, hidden receive copy
  // ----------------------------------------------------------------
  baud_counter txTimer (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .tick        (timerTick),
    .forceReload (1'b0),
    .reloadByte  (reload),
    .count       (txCount),
    .bitTick     (txBitTick)
  );

  baud_counter rxTimer (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .tick        (timerTick),
    .forceReload (startSeen),
    .reloadByte  (reload),
    .count       (rxCount),
    .bitTick     (rxBitTick)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Frame: low start, data LSB first, optional ninth, high stop
  always_comb begin
    next_txState = txState;
    next_txShift = txShift;
    next_txLeft  = txLeft;
    next_txPin   = txPin;
    txDoneSet    = 1'b0;
    case (txState)
      TX_IDLE: begin
        next_txPin = 1'b1;
        if (req.wr && req.addr == serial_port_pkg::ADDR_DATA) begin
          next_txShift = {control[serial_port_pkg::CTL_TB8], req.wdata};
          next_txLeft  = frameBits(control[serial_port_pkg::CTL_MODE]);
          next_txState = TX_START;
        end
      end
      TX_START: begin
        if (txBitTick) begin
          next_txPin   = 1'b0;
          next_txState = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (txBitTick) begin
          if (txLeft == 4'h0) begin
            next_txState = TX_IDLE; // Stop bit time ends
          end else if (txLeft == 4'h1) begin
            next_txPin  = 1'b1;
            next_txLeft = 4'h0;
            txDoneSet   = 1'b1;
          end else begin
            next_txPin   = txShift[0];
            next_txShift = {1'b1, txShift[8:1]};
            next_txLeft  = txLeft - 4'h1;
          end
        end
      end
      default: next_txState = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      txState <= TX_IDLE;
      txShift <= 9'h1ff;
      txLeft  <= 4'h0;
      txPin   <= 1'b1;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txLeft  <= next_txLeft;
      txPin   <= next_txPin;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Bit ticks run at the bit rate from the forced reload, so sampling
  // happens after a half period phase step: mid-bit by construction
  assign startSeen = (rxState == RX_IDLE) && control[serial_port_pkg::CTL_REN]
                     && !rxSync[1];
  // Next shift value: in the 8-bit mode the stop bit shifts in on the storing tick
  assign rxWord    = '{data: next_rxShift[7:0], ninth: next_rxShift[8]};

  always_comb begin
    logic okBit;
    okBit        = 1'b0;
    next_rxState = rxState;
    next_rxShift = rxShift;
    next_rxLeft  = rxLeft;
    next_rxPhase = rxPhase;
    rxDoneSet    = 1'b0;
    case (rxState)
      RX_IDLE: begin
        if (startSeen) begin
          next_rxState = RX_START;
          next_rxLeft  = frameBits(control[serial_port_pkg::CTL_MODE]);
          next_rxPhase = 1'b0;
        end
      end
      RX_START: begin
        if (rxBitTick) begin
          next_rxState = rxSync[1] ? RX_IDLE : RX_SHIFT; // False start rejected
        end
      end
      RX_SHIFT: begin
        if (rxBitTick) begin
          if (rxLeft == 4'h1) begin
            okBit = control[serial_port_pkg::CTL_MODE] ? rxShift[8] : rxSync[1];
            if (!control[serial_port_pkg::CTL_MODE]) begin
              next_rxShift = {rxSync[1], rxShift[8:1]}; // Stop bit into ninth
            end
            // Overrun: the earlier byte is kept, the new one dropped
            if (!control[serial_port_pkg::CTL_RI] &&
                (!control[serial_port_pkg::CTL_MCE] || okBit)) begin
              rxDoneSet = 1'b1;
            end
            next_rxState = RX_IDLE;
          end else begin
            next_rxShift = {rxSync[1], rxShift[8:1]};
            next_rxLeft  = rxLeft - 4'h1;
          end
        end
      end
      default: next_rxState = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxState <= RX_IDLE;
      rxShift <= 9'h000;
      rxLeft  <= 4'h0;
      rxPhase <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxShift <= next_rxShift;
      rxLeft  <= next_rxLeft;
      rxPhase <= next_rxPhase;
    end
  end

  // ----------------------------------------------------------------
  // Register file, flags and interrupt
  // ----------------------------------------------------------------
  // Hardware set beats a software clear in the same cycle
  always_comb begin
    logic [7:0] status;
    status         = {6'h00, control[serial_port_pkg::CTL_TI],
                      control[serial_port_pkg::CTL_RI]};
    next_control   = control;
    next_rxBuf     = rxBuf;
    next_reload    = reload;
    next_timerCfg  = timerCfg;
    next_irqMask   = irqMask;
    next_regRdata  = serial_port_pkg::UNMAPPED_READ;
    if (req.wr) begin
      case (req.addr)
        serial_port_pkg::ADDR_CONTROL: next_control = {req.wdata[7], 1'b0, req.wdata[5:0]};
        serial_port_pkg::ADDR_RELOAD:  next_reload  = req.wdata;
        serial_port_pkg::ADDR_TIMER:   next_timerCfg = req.wdata[2:0];
        serial_port_pkg::ADDR_STATUS:  next_control[1:0] = control[1:0] & ~req.wdata[1:0];
        serial_port_pkg::ADDR_MASK:    next_irqMask = req.wdata[1:0];
        default:                       next_control = control;
      endcase
    end
    if (txDoneSet) next_control[serial_port_pkg::CTL_TI] = 1'b1;
    if (rxDoneSet) begin
      next_control[serial_port_pkg::CTL_RI]  = 1'b1;
      next_control[serial_port_pkg::CTL_RB8] = rxWord.ninth;
      next_rxBuf = rxWord.data;
    end
    if (req.rd) begin
      case (req.addr)
        serial_port_pkg::ADDR_CONTROL: next_regRdata = control | 8'h40;
        serial_port_pkg::ADDR_DATA:    next_regRdata = rxBuf;
        serial_port_pkg::ADDR_RELOAD:  next_regRdata = reload;
        serial_port_pkg::ADDR_TIMER:   next_regRdata = txCount;
        serial_port_pkg::ADDR_STATUS:  next_regRdata = status;
        serial_port_pkg::ADDR_MASK:    next_regRdata = {6'h00, irqMask};
        default:                       next_regRdata = serial_port_pkg::UNMAPPED_READ;
      endcase
    end
    next_irq = |(next_control[1:0] & next_irqMask);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      control  <= serial_port_pkg::CONTROL_RESET;
      rxBuf    <= serial_port_pkg::DATA_RESET;
      reload   <= serial_port_pkg::RELOAD_RESET;
      timerCfg <= serial_port_pkg::TIMER_RESET;
      irqMask  <= serial_port_pkg::IRQ_RESET;
      regRdata <= serial_port_pkg::UNMAPPED_READ;
      irq      <= 1'b0;
    end else begin
      control  <= next_control;
      rxBuf    <= next_rxBuf;
      reload   <= next_reload;
      timerCfg <= next_timerCfg;
      irqMask  <= next_irqMask;
      regRdata <= next_regRdata;
      irq      <= next_irq;
    end
  end

endmodule

// ---- async_serial_port_sva.sv ----
/*
  Checker for the serial port top: register port answers and line timing.
  Assumes one clock domain and the register map of the shared package.
*/
`timescale 1ns/1ns
module async_serial_port_sva (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regRdata,
  input  wire logic       rxPin,
  input  wire logic       extClkPin,
  input  wire logic       txPin,
  input  wire logic       irq
);
  // ------------------------------------------------------------
  // Decoded strobes
  // ------------------------------------------------------------
  localparam logic [3:0] A_CTL = serial_port_pkg::ADDR_CONTROL;
  localparam logic [3:0] A_RLD = serial_port_pkg::ADDR_RELOAD;
  localparam logic [3:0] A_MSK = serial_port_pkg::ADDR_MASK;
  logic wCtl, rCtl, wRld, rRld, wMsk, rMsk;
  // Short names keep each property on one line
  assign wCtl = regWr && regAddr == A_CTL;
  assign rCtl = regRd && regAddr == A_CTL;
  assign wRld = regWr && regAddr == A_RLD;
  assign rRld = regRd && regAddr == A_RLD;
  assign wMsk = regWr && regAddr == A_MSK;
  assign rMsk = regRd && regAddr == A_MSK;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  rd_idle_zero_a: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (regRd && regAddr > A_MSK |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  mask_off_a: assert property (wMsk && regWdata[1:0] == 2'h0 |=> ##1 !irq)
    else $error("interrupt high with empty mask");
  // Reset check runs through reset, so it opts out of the default disable
  reset_idle_a: assert property (disable iff (1'b0) !resetn |=> txPin && !irq)
    else $error("outputs not idle in reset");
  // Shortest bit is eight clocks: fastest tick, one count, halved
  bit_hold_a: assert property ($changed(txPin) |=> $stable(txPin)[*7])
    else $error("line level shorter than a bit");
  ctl_back_a: assert property (wCtl ##2 rCtl |=> regRdata[7:3] == ($past(regWdata[7:3], 3) | 5'h08))
    else $error("control readback wrong");
  rld_back_a: assert property (wRld ##2 rRld |=> regRdata == $past(regWdata, 3))
    else $error("reload readback wrong");
  msk_back_a: assert property (wMsk ##2 rMsk |=> regRdata[1:0] == $past(regWdata[1:0], 3))
    else $error("mask readback wrong");

  frame_c: cover property ($fell(txPin));
  irq_c: cover property ($rose(irq));
  hole_c: cover property (regRd && regAddr > A_MSK);
endmodule
bind async_serial_port async_serial_port_sva async_serial_port_sva_inst (
  .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxPin(rxPin),
  .extClkPin(extClkPin), .txPin(txPin), .irq(irq));

// ---- serial_node.sv ----
/*
  Remote serial node: sends frames onto the port's receive pin and
  captures frames from its transmit pin.
  Assumes the bench sets bitCycles to the port's bit time in clocks.
*/
`timescale 1ns/1ns
module serial_node (
  input  wire logic sys_clk,
  input  wire logic txPin,
  output logic      rxPin
);
  // ------------------------------------------------------------
  // State seen by the bench
  // ------------------------------------------------------------
  int         bitCycles = 16;
  int         startLen;
  logic [7:0] gotData;
  logic       gotNinth;
  logic       gotStop;

  // Line idles high between frames
  initial rxPin = 1'b1;

  // ------------------------------------------------------------
  // Frame tasks
  // ------------------------------------------------------------
  // Start low, data least significant first, optional ninth, stop high
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth);
    logic [10:0] f;
    f = nine ? {1'b1, ninth, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxPin <= f[i];
      repeat (bitCycles) @(posedge sys_clk);
    end
  endtask

  // Measure the start bit, then sample each later bit in its middle
  task automatic capture(input logic nine);
    logic [9:0] b;
    @(posedge sys_clk);
    while (txPin !== 1'b0) @(posedge sys_clk);
    startLen = 0;
    while (txPin === 1'b0) begin
      startLen++;
      @(posedge sys_clk);
    end
    repeat (bitCycles / 2) @(posedge sys_clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      b[i] = txPin;
      if (i < (nine ? 9 : 8)) repeat (bitCycles) @(posedge sys_clk);
    end
    gotData = b[7:0];
    gotNinth = nine ? b[8] : 1'b1;
    gotStop = nine ? b[9] : b[8];
  endtask
endmodule

// ---- async_serial_port_bench.sv ----
/*
  Self-checking bench: a table of duplex frames over every timer clock
  source, then hand tests for buffering, overrun, address check and masking.
  Assumes the node model and the checker are compiled before it.
*/
`timescale 1ns/1ns
module async_serial_port_bench;
  // ------------------------------------------------------------
  // Signals and table
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] src;
    logic       mode;
    logic       tb8;
    logic [7:0] txByte;
    logic [7:0] rxByte;
    logic       rxNinth;
  } row_t;
  localparam logic [3:0] A_CTL = serial_port_pkg::ADDR_CONTROL;
  localparam logic [3:0] A_DAT = serial_port_pkg::ADDR_DATA;
  localparam logic [3:0] A_RLD = serial_port_pkg::ADDR_RELOAD;
  localparam logic [3:0] A_TMR = serial_port_pkg::ADDR_TIMER;
  localparam logic [3:0] A_STS = serial_port_pkg::ADDR_STATUS;
  localparam logic [3:0] A_MSK = serial_port_pkg::ADDR_MASK;
  localparam logic [7:0] RELOAD = 8'hfe;
  localparam int LIMIT = 40000;
  logic sys_clk, resetn, regWr, regRd, rxPin, extClkPin, txPin, irq;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, v, ctl;
  int n_fail, compares, cycles;
  // Transmit bytes all end in a one, so the start bit length is measurable
  row_t rows [4] = '{'{2'h0, 1'b0, 1'b0, 8'ha5, 8'h5a, 1'b1},
                     '{2'h1, 1'b1, 1'b1, 8'h3d, 8'hc3, 1'b0},
                     '{2'h2, 1'b1, 1'b0, 8'h81, 8'h7e, 1'b1},
                     '{2'h3, 1'b0, 1'b1, 8'hff, 8'h00, 1'b1}};

  async_serial_port async_serial_port_inst (.sys_clk(sys_clk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rxPin(rxPin), .extClkPin(extClkPin), .txPin(txPin), .irq(irq));
  serial_node serial_node_inst (.sys_clk(sys_clk), .txPin(txPin), .rxPin(rxPin));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // External timer clock: a rising edge every two system clocks
  always @(posedge sys_clk) extClkPin <= ~extClkPin;
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles leave a quiet cycle after the strobe so no signal is set twice
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    v = regRdata;
  endtask
  // Poll for receive-done, bounded so a dropped frame cannot hang
  task automatic waitRx();
    v = 8'h00;
    for (int i = 0; i < 300 && v[0] !== 1'b1; i++) rd(A_STS);
  endtask
  function automatic int tickDiv(input logic [1:0] s);
    case (s)
      2'h0: return 4;
      2'h1: return 12;
      2'h2: return 48;
      default: return 16;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    extClkPin = 1'b0;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    check("tx idle", {7'h00, txPin}, 8'h01);
    check("irq idle", {7'h00, irq}, 8'h00);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(A_CTL);
    check("control reset", v, 8'h40);
    rd(4'hf);
    check("unmapped", v, 8'h00);
    wr(A_RLD, RELOAD);
    rd(A_RLD);
    check("reload", v, RELOAD);
    wr(A_MSK, 8'h00);
    wr(A_MSK, 8'h03);
    foreach (rows[i]) begin
      serial_node_inst.bitCycles = tickDiv(rows[i].src) * 2 * (256 - RELOAD);
      wr(A_TMR, {5'h00, 1'b1, rows[i].src});
      ctl = {rows[i].mode, 3'b001, rows[i].tb8, 3'b000};
      wr(A_CTL, ctl);
      rd(A_CTL);
      check("control", v, ctl | 8'h40);
      fork
        serial_node_inst.capture(rows[i].mode);
        wr(A_DAT, rows[i].txByte);
        serial_node_inst.send(rows[i].rxByte, rows[i].mode, rows[i].rxNinth);
      join
      // Let the transmitter leave its stop bit before the timer is retuned
      repeat (serial_node_inst.bitCycles) @(posedge sys_clk);
      waitRx();
      check("both done", v & 8'h03, 8'h03);
      check("irq set", {7'h00, irq}, 8'h01);
      check("tx data", serial_node_inst.gotData, rows[i].txByte);
      check("tx ninth", {7'h00, serial_node_inst.gotNinth}, {7'h00, rows[i].mode ? rows[i].tb8 : 1'b1});
      check("tx stop", {7'h00, serial_node_inst.gotStop}, 8'h01);
      check("bit time", 8'(serial_node_inst.startLen), 8'(tickDiv(rows[i].src) * 2 * (256 - RELOAD)));
      rd(A_DAT);
      check("rx data", v, rows[i].rxByte);
      rd(A_CTL);
      check("rx ninth", {7'h00, v[2]}, {7'h00, rows[i].mode ? rows[i].rxNinth : 1'b1});
      wr(A_STS, 8'h03);
      rd(A_STS);
      check("cleared", v & 8'h03, 8'h00);
      check("irq clear", {7'h00, irq}, 8'h00);
    end
    serial_node_inst.bitCycles = 16;
    wr(A_TMR, 8'h04);
    wr(A_CTL, 8'h10);
    serial_node_inst.send(8'h11, 1'b0, 1'b1);
    waitRx();
    // Held byte stays readable while the next one arrives
    fork
      serial_node_inst.send(8'h22, 1'b0, 1'b1);
      begin
        rd(A_DAT);
        check("held byte", v, 8'h11);
        wr(A_STS, 8'h01);
      end
    join
    waitRx();
    rd(A_DAT);
    check("next byte", v, 8'h22);
    serial_node_inst.send(8'h33, 1'b0, 1'b1);
    rd(A_DAT);
    check("overrun", v, 8'h22);
    wr(A_CTL, 8'hb0);
    serial_node_inst.send(8'h44, 1'b1, 1'b0);
    waitRx();
    check("data byte dropped", v & 8'h01, 8'h00);
    serial_node_inst.send(8'h55, 1'b1, 1'b1);
    waitRx();
    rd(A_DAT);
    check("address byte", v, 8'h55);
    wr(A_CTL, 8'h00);
    serial_node_inst.send(8'h66, 1'b0, 1'b1);
    waitRx();
    check("rx disabled", v & 8'h01, 8'h00);
    wr(A_CTL, 8'h10);
    wr(A_MSK, 8'h02);
    serial_node_inst.send(8'h77, 1'b0, 1'b1);
    waitRx();
    check("masked irq", {7'h00, irq}, 8'h00);
    wr(A_MSK, 8'h01);
    rd(A_MSK);
    check("unmasked irq", {7'h00, irq}, 8'h01);
    end_sim();
  end
endmodule
